// ### cst_cfg.svh
// Register offsets, field positions, reset value, write mask and tick-counter tap bits of the tick timer
`ifndef CST_CFG_SVH
`define CST_CFG_SVH
`define CST_ADDR_CTRL        8'h00
`define CST_ADDR_TICK        8'h04
`define CST_ADDR_PKT         8'h08
`define CST_BIT_TICK_EN      0
`define CST_LSB_RELOAD       1
`define CST_LSB_INIT         5
`define CST_BIT_TAP          9
`define CST_BIT_PC_EN        12
`define CST_BIT_EXC_EN       16
`define CST_BIT_EVT_EN       22
`define CST_BIT_NO_TICK      25
`define CST_BIT_NO_TRC       27
`define CST_TAP_LO           6
`define CST_TAP_HI           10
`define CST_CTRL_RESET       32'h0000_0000
`define CST_CTRL_WMASK       32'h0041_13ff
`endif

// ### cst_pkg.sv
// Types shared by the tick timer block
package cst_pkg;
   typedef enum logic [2:0] {
      CST_PKT_NONE = 3'b001,
      CST_PKT_PC   = 3'b010,
      CST_PKT_CYC  = 3'b100
   } cst_pkt_t;
   typedef enum logic [1:0] {
      CST_EXC_ENTER  = 2'h1,
      CST_EXC_EXIT   = 2'h2,
      CST_EXC_RESUME = 2'h3
   } cst_exc_t;
endpackage

// ### cst_countdown.sv
// Four-bit countdown driven by tick-counter tap transitions
`include "cst_cfg.svh"
module cst_countdown
   import cst_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,       // Processor clock
   input  wire logic             rstN,      // Synchronised reset
   input  wire logic             tapBit,    // Selected tap bit
   input  wire logic             load,      // Load initial value
   input  wire logic             run,       // Countdown enabled
   input  wire logic [WIDTH-1:0] initVal,   // Initial value
   input  wire logic [WIDTH-1:0] reloadVal, // Reload value
   output logic                  underflow  // Pulse on reload
);
   logic             tapPrev_reg;
   logic [WIDTH-1:0] count_reg;
   logic             edgeSeen;

   assign edgeSeen = tapBit ^ tapPrev_reg;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         tapPrev_reg <= 1'b0;
      end else begin
         tapPrev_reg <= tapBit;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count_reg <= '0;
         underflow <= 1'b0;
      end else begin
         underflow <= 1'b0;
         if (load) begin
            count_reg <= initVal;
         end else if (run && edgeSeen) begin
            if (count_reg != '0) begin
               count_reg <= count_reg - 1'b1;
            end else begin
               count_reg <= reloadVal;
               underflow <= 1'b1;
            end
         end
      end
   end
endmodule

// ### cst_exc_trace.sv
// Exception trace packet trigger
module cst_exc_trace
   import cst_pkg::*;
(
   input  wire logic     clk,      // Processor clock
   input  wire logic     rstN,     // Synchronised reset
   input  wire logic     enable,   // Exception trace enable
   input  wire logic     excEnter, // Handler entry
   input  wire logic     excExit,  // Handler exit by return vector
   input  wire logic     excResume,// Preempted code resumed
   output logic          pktValid, // Packet pulse
   output cst_exc_t      pktKind   // Packet kind
);
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pktValid <= 1'b0;
         pktKind  <= CST_EXC_ENTER;
      end else begin
         pktValid <= enable && (excEnter || excExit || excResume);
         if (excEnter) begin
            pktKind <= CST_EXC_ENTER;
         end else if (excExit) begin
            pktKind <= CST_EXC_EXIT;
         end else if (excResume) begin
            pktKind <= CST_EXC_RESUME;
         end
      end
   end
endmodule

// ### cst_top.sv
// Tick counter, sample countdown and trace triggers with AXI4-Lite registers
`include "cst_cfg.svh"
module cst_top
   import cst_pkg::*;
#(
   parameter bit HAS_TICK  = 1'b1,
   parameter bit HAS_TRACE = 1'b1
) (
   input  wire logic        clk,            // Processor clock, 200 MHz
   input  wire logic        rst_n,          // Async reset, active low
   input  wire logic        haltedDebug,    // Core halted in debug state
   input  wire logic        excEnter,       // Exception entry pulse
   input  wire logic        excExit,        // Exception exit pulse
   input  wire logic        excResume,      // Return to preempted code pulse
   output logic             excPktValid,    // Exception packet pulse
   output cst_exc_t         excPktKind,     // Exception packet kind
   output logic             pcSamplePkt,    // Periodic PC sample packet pulse
   output logic             cycEventPkt,    // Event packet pulse, cycle flag
   output logic             cycFlag,        // Cycle flag of event packet
   input  wire logic [7:0]  s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [7:0]  s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready    // Read data ready
);
   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rstSync_reg;
   logic       rstN;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_reg <= 2'b00;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end
   assign rstN = rstSync_reg[1];

   // ****************************************
   // AXI4-Lite write path
   // ****************************************
   logic        awHeld_reg;
   logic [7:0]  awAddr_reg;
   logic        wHeld_reg;
   logic [31:0] wData_reg;
   logic [3:0]  wStrb_reg;
   logic        doWrite;
   logic [31:0] strbMask;
   logic [31:0] ctrl_reg;
   logic [31:0] ctrlNext;
   logic [31:0] tick_reg;
   logic        ctrlWr;
   logic        tickWr;
   logic        wrOk;

   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
   assign doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign strbMask      = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
                           {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
   assign ctrlWr        = doWrite && (awAddr_reg == `CST_ADDR_CTRL);
   assign tickWr        = doWrite && (awAddr_reg == `CST_ADDR_TICK);
   assign ctrlNext      = (ctrl_reg & ~(strbMask & `CST_CTRL_WMASK))
                        | (wData_reg & strbMask & `CST_CTRL_WMASK);

   always_comb begin
      if (awAddr_reg == `CST_ADDR_CTRL) begin
         wrOk = 1'b1;
      end else if (awAddr_reg == `CST_ADDR_TICK) begin
         wrOk = 1'b1;
      end else if (awAddr_reg == `CST_ADDR_PKT) begin
         wrOk = 1'b1;
      end else begin
         wrOk = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wHeld_reg  <= 1'b0;
         wData_reg  <= 32'h0000_0000;
         wStrb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end else if (doWrite) begin
            awHeld_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrOk ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // Control register and enables
   // ****************************************
   logic tickEn;
   logic pcEn;
   logic evtEn;
   logic excEn;
   logic tapSel;
   logic pktAllowed;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_reg <= `CST_CTRL_RESET;
      end else if (ctrlWr) begin
         ctrl_reg <= ctrlNext;
      end
   end

   assign tickEn     = HAS_TICK && ctrl_reg[`CST_BIT_TICK_EN];
   assign pcEn       = ctrl_reg[`CST_BIT_PC_EN];
   assign evtEn      = ctrl_reg[`CST_BIT_EVT_EN];
   assign excEn      = HAS_TRACE && ctrl_reg[`CST_BIT_EXC_EN];
   assign tapSel     = ctrl_reg[`CST_BIT_TAP];
   assign pktAllowed = HAS_TICK && HAS_TRACE;

   // ****************************************
   // Tick counter
   // ****************************************
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         tick_reg <= 32'h0000_0000;
      end else if (tickWr && HAS_TICK) begin
         tick_reg <= (tick_reg & ~strbMask) | (wData_reg & strbMask);
      end else if (tickEn && !haltedDebug) begin
         tick_reg <= tick_reg + 32'h0000_0001;
      end
   end

   // ****************************************
   // Sample countdown control
   // ****************************************
   logic       cdLoad;
   logic       cdRun;
   logic       cdUnder;
   logic       tapBit;
   logic       anyEnNow;
   logic       anyEnNext;
   logic       tickEnNext;

   assign tapBit     = tapSel ? tick_reg[`CST_TAP_HI] : tick_reg[`CST_TAP_LO];
   assign anyEnNow   = pcEn || evtEn;
   assign anyEnNext  = ctrlNext[`CST_BIT_PC_EN] || ctrlNext[`CST_BIT_EVT_EN];
   assign tickEnNext = ctrlNext[`CST_BIT_TICK_EN];
   // Load on enables leaving both-zero, or on counter enable rising
   assign cdLoad = ctrlWr && ((anyEnNext && !anyEnNow)
                 || (tickEnNext && !tickEn && HAS_TICK));
   // Halt freezes the tap bit, so no gate here; a transition at halt onset still counts
   assign cdRun  = tickEn && anyEnNow && pktAllowed;

   cst_countdown #(
      .WIDTH (4)
   ) uCountdown (
      .clk       (clk),
      .rstN      (rstN),
      .tapBit    (tapBit),
      .load      (cdLoad),
      .run       (cdRun),
      .initVal   (ctrlNext[`CST_LSB_INIT +: 4]),
      .reloadVal (ctrl_reg[`CST_LSB_RELOAD +: 4]),
      .underflow (cdUnder)
   );

   // ****************************************
   // Periodic packet triggers
   // ****************************************
   cst_pkt_t pktSel;

   always_comb begin
      if (pcEn) begin
         pktSel = CST_PKT_PC;
      end else if (evtEn) begin
         pktSel = CST_PKT_CYC;
      end else begin
         pktSel = CST_PKT_NONE;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pcSamplePkt <= 1'b0;
         cycEventPkt <= 1'b0;
         cycFlag     <= 1'b0;
      end else begin
         pcSamplePkt <= cdUnder && (pktSel == CST_PKT_PC);
         cycEventPkt <= cdUnder && (pktSel == CST_PKT_CYC);
         cycFlag     <= cdUnder && (pktSel == CST_PKT_CYC);
      end
   end

   // ****************************************
   // Exception trace
   // ****************************************
   cst_exc_trace uExcTrace (
      .clk       (clk),
      .rstN      (rstN),
      .enable    (excEn),
      .excEnter  (excEnter),
      .excExit   (excExit),
      .excResume (excResume),
      .pktValid  (excPktValid),
      .pktKind   (excPktKind)
   );

   // ****************************************
   // AXI4-Lite read path
   // ****************************************
   logic [31:0] ctrlRead;
   logic [31:0] rdData;
   logic        rdOk;
   logic [15:0] pktCount_reg;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pktCount_reg <= 16'h0000;
      end else if (pcSamplePkt || cycEventPkt) begin
         pktCount_reg <= pktCount_reg + 16'h0001;
      end
   end

   always_comb begin
      ctrlRead = ctrl_reg;
      ctrlRead[`CST_BIT_NO_TRC]  = !HAS_TRACE;
      ctrlRead[`CST_BIT_NO_TICK] = !HAS_TICK;
   end

   always_comb begin
      if ({s_axi_araddr[7:2], 2'b00} == `CST_ADDR_CTRL) begin
         rdData = ctrlRead;
         rdOk   = 1'b1;
      end else if ({s_axi_araddr[7:2], 2'b00} == `CST_ADDR_TICK) begin
         rdData = tick_reg;
         rdOk   = 1'b1;
      end else if ({s_axi_araddr[7:2], 2'b00} == `CST_ADDR_PKT) begin
         rdData = {16'h0000, pktCount_reg};
         rdOk   = 1'b1;
      end else begin
         rdData = 32'h0000_0000;
         rdOk   = 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdData;
         s_axi_rresp  <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ### cst_top_asserts.sv
// Port-level checker for the tick timer block
module cst_top_asserts
   import cst_pkg::*;
(
   input wire logic     clk,         // Processor clock
   input wire logic     rst_n,       // Async reset, active low
   input wire logic     haltedDebug, // Core halted
   input wire logic     excEnter,    // Entry event
   input wire logic     excExit,     // Exit event
   input wire logic     excResume,   // Resume event
   input wire logic     excPktValid, // Exception packet
   input wire cst_exc_t excPktKind,  // Exception packet kind
   input wire logic     pcSamplePkt, // PC sample packet
   input wire logic     cycEventPkt, // Event packet
   input wire logic     cycFlag      // Cycle flag
);
   // ****************
   // Assertions
   // ****************
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   exc_cause_a: assert property (excPktValid |-> $past(excEnter || excExit || excResume))
      else $error("exception packet without an event");
   exc_enter_a: assert property ($past(excEnter) && excPktValid |-> excPktKind == CST_EXC_ENTER)
      else $error("entry packet kind wrong");
   exc_exit_a: assert property ($past(excExit && !excEnter) && excPktValid |-> excPktKind == CST_EXC_EXIT)
      else $error("exit packet kind wrong");
   exc_resume_a: assert property ($past(excResume && !excEnter && !excExit) && excPktValid
      |-> excPktKind == CST_EXC_RESUME)
      else $error("resume packet kind wrong");
   pkt_exclusive_a: assert property (!(pcSamplePkt && cycEventPkt))
      else $error("both periodic packets at once");
   cyc_flag_a: assert property (cycEventPkt |-> cycFlag)
      else $error("event packet without cycle flag");
   pc_spacing_a: assert property (pcSamplePkt |=> !pcSamplePkt [*8])
      else $error("PC sample packets too close");
   evt_spacing_a: assert property (cycEventPkt |=> !cycEventPkt [*8])
      else $error("event packets too close");
   halt_quiet_a: assert property (haltedDebug [*4] |-> !pcSamplePkt && !cycEventPkt)
      else $error("periodic packet while halted");
endmodule

bind cst_top cst_top_asserts i_cst_top_asserts (.clk(clk), .rst_n(rst_n),
   .haltedDebug(haltedDebug), .excEnter(excEnter), .excExit(excExit),
   .excResume(excResume), .excPktValid(excPktValid), .excPktKind(excPktKind),
   .pcSamplePkt(pcSamplePkt), .cycEventPkt(cycEventPkt), .cycFlag(cycFlag));

// ### cst_core_model.sv
// Core exception event source and trace packet sink
module cst_core_model
   import cst_pkg::*;
(
   input  wire logic     clk,         // Processor clock
   output logic          excEnter,    // Entry pulse
   output logic          excExit,     // Exit pulse
   output logic          excResume,   // Resume pulse
   input  wire logic     excPktValid, // Packet pulse
   input  wire logic [1:0] excPktKind // Packet kind
);
   timeunit 1ns;
   timeprecision 100ps;
   int       pktCount;
   logic [1:0] lastKind;
   initial begin
      excEnter = 1'b0;
      excExit = 1'b0;
      excResume = 1'b0;
      pktCount = 0;
   end
   // ****************
   // Packet sink
   // ****************
   always @(posedge clk) begin
      if (excPktValid === 1'b1) begin
         pktCount <= pktCount + 1;
         lastKind <= excPktKind;
      end
   end
   // One-cycle event pulse, launched after a rising edge
   task automatic fire(input int k);
      excEnter <= (k == 1);
      excExit <= (k == 2);
      excResume <= (k == 3);
      @(posedge clk);
      excEnter <= 1'b0;
      excExit <= 1'b0;
      excResume <= 1'b0;
   endtask
endmodule

// ### cst_top_tb.sv
// Self-checking bench of the tick timer block
`include "cst_cfg.svh"
module cst_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rstN = 1'b0;
   logic        halted = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   wire         eEn, eEx, eRs, pktV, pcPkt, evPkt, cFlag;
   wire         awready, wready, bvalid, arready, rvalid;
   wire [1:0]   bresp, rresp, pktK;
   wire [31:0]  rdata;
   int          mismatches = 0;
   int          n_tests = 0;
   int          nPc = 0;
   int          nEvt = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (pcPkt === 1'b1) nPc++;
      if (evPkt === 1'b1 && cFlag === 1'b1) nEvt++;
   end

   cst_top i_cst_top (.clk(clk), .rst_n(rstN), .haltedDebug(halted), .excEnter(eEn),
      .excExit(eEx), .excResume(eRs), .excPktValid(pktV), .excPktKind(pktK),
      .pcSamplePkt(pcPkt), .cycEventPkt(evPkt), .cycFlag(cFlag), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cst_core_model i_cst_core_model (.clk(clk), .excEnter(eEn), .excExit(eEx),
      .excResume(eRs), .excPktValid(pktV), .excPktKind(pktK));

   // ****************
   // Tasks
   // ****************
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write one word; each channel dropped at its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      hb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 64 && !hb; n++) begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         if (hb) chk("bresp", {30'h0, er}, {30'h0, bresp});
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
      @(posedge clk);
      if (!hb) begin
         mismatches++;
         conclude();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed,
                     input string nm);
      logic ha, hr;
      hr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 64 && !hr; n++) begin
         @(negedge clk);
         ha = arvalid && arready;
         hr = rvalid;
         if (hr) chk("rresp", {30'h0, er}, {30'h0, rresp});
         if (hr) chk(nm, ed, rdata);
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
      @(posedge clk);
      if (!hr) begin
         mismatches++;
         conclude();
      end
   endtask

   // ****************
   // Main sequence
   // ****************
   initial begin
      logic [31:0] base, cv;
      int          init, rld, t, e, c, tot;
      void'($urandom(32'h524d91c4));
      repeat (16) @(posedge clk);
      rstN <= 1'b1;
      repeat (3) @(posedge clk);
      rd(`CST_ADDR_CTRL, 2'b00, `CST_CTRL_RESET, "ctrl reset");
      wr(`CST_ADDR_CTRL, 32'hffff_ffff, 2'b00);
      rd(`CST_ADDR_CTRL, 2'b00, `CST_CTRL_WMASK, "ctrl mask");
      wr(8'h0c, 32'h1, 2'b10);
      rd(8'h0c, 2'b10, 32'h0, "unmapped");
      $display("test registers done");
      base = 32'hffff_ffff - ($urandom % 40);
      wr(`CST_ADDR_CTRL, 32'h1, 2'b00);
      wr(`CST_ADDR_TICK, base, 2'b00);
      rd(`CST_ADDR_TICK, 2'b00, base, "tick load");
      halted <= 1'b0;
      repeat (50) @(posedge clk);
      halted <= 1'b1;
      rd(`CST_ADDR_TICK, 2'b00, base + 32'd50, "tick wrap");
      wr(`CST_ADDR_CTRL, 32'h0, 2'b00);
      halted <= 1'b0;
      repeat (20) @(posedge clk);
      halted <= 1'b1;
      rd(`CST_ADDR_TICK, 2'b00, base + 32'd50, "tick gated");
      $display("test tick counter done");
      for (int m = 0; m < 4; m++) begin
         init = $urandom % 4;
         rld = $urandom % 4;
         t = (m == 3) ? 3 : 20;
         wr(`CST_ADDR_CTRL, 32'h0, 2'b00);
         wr(`CST_ADDR_TICK, 32'h0, 2'b00);
         cv = 32'(init) << 5 | 32'(rld) << 1 | 32'(m == 3) << 9 | 32'h1;
         wr(`CST_ADDR_CTRL, cv, 2'b00);
         cv = cv | 32'(m != 1) << 12 | 32'(m == 1 || m == 2) << 22;
         wr(`CST_ADDR_CTRL, cv, 2'b00);
         nPc = 0;
         nEvt = 0;
         halted <= 1'b0;
         repeat (((m == 3) ? 1024 : 64) * t + 32) @(posedge clk);
         halted <= 1'b1;
         repeat (4) @(posedge clk);
         e = (t > init) ? 1 + (t - init - 1) / (rld + 1) : 0;
         chk("pc packets", 32'((m != 1) ? e : 0), 32'(nPc));
         chk("event packets", 32'((m == 1) ? e : 0), 32'(nEvt));
         tot += e;
         $display("test periodic mode %0d done", m);
      end
      rd(`CST_ADDR_PKT, 2'b00, 32'(tot), "pkt count");
      for (int en = 0; en < 2; en++) begin
         wr(`CST_ADDR_CTRL, 32'(en) << 16, 2'b00);
         for (int k = 1; k < 4; k++) begin
            c = i_cst_core_model.pktCount;
            i_cst_core_model.fire(k);
            repeat (2) @(posedge clk);
            chk("exc count", 32'(c + en), 32'(i_cst_core_model.pktCount));
            if (en == 1) chk("exc kind", 32'(k), 32'(i_cst_core_model.lastKind));
         end
      end
      $display("test exception trace done");
      conclude();
   end
endmodule
